// ### hdl/ipc_pkg.sv
// Purpose: shared constants and types for the I2C proxy controller
// Assumes: 100 MHz system clock, 40 ns nominal timing unit
// Notes: offsets are byte addresses on the local register port
package ipc_pkg;
  localparam int NUM_PORTS = 2;
  // Register offsets
  localparam logic [7:0] OFS_GEN_CTRL = 8'h05;
  localparam logic [7:0] OFS_PROXY_STS = 8'h07;
  localparam logic [7:0] OFS_SCL_HIGH = 8'h0A;
  localparam logic [7:0] OFS_SCL_LOW = 8'h0B;
  localparam logic [7:0] OFS_PORT_SEL = 8'h4C;
  // Field layouts and reset values
  localparam int GEN_PERMIT_BIT = 2;
  localparam logic [7:0] GEN_CTRL_MASK = 8'h04;
  localparam logic [7:0] GEN_CTRL_RESET = 8'h00;
  localparam logic [7:0] PORT_SEL_MASK = 8'h33;
  localparam logic [7:0] PORT_SEL_RESET = 8'h01;
  localparam int SEL_WR_LSB = 0;
  localparam int SEL_RD_LSB = 4;
  localparam int STS_ACTIVE_LSB = 0;
  localparam int STS_BUS_BUSY_BIT = 4;
  localparam int STS_REF_BIT = 5;
  localparam logic [7:0] SCL_HIGH_RESET = 8'h7A;
  localparam logic [7:0] SCL_LOW_RESET = 8'h7A;
  // Timing
  localparam int SCL_EXTRA_UNITS = 4;
  localparam int CLK_PERIOD_NS = 10;
  localparam int UNIT_NS = 40;
  localparam int UNIT_CYCLES = (UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REF_LOSS_NS = 160;
  localparam int REF_LOSS_CYCLES = REF_LOSS_NS / CLK_PERIOD_NS;
  // Frame layout: address byte, ack, data byte, ack
  localparam int ADDR_ACK_BIT = 8;
  localparam int FRAME_LAST_BIT = 17;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT_BUS,
    ST_START,
    ST_LOW,
    ST_HIGH,
    ST_STOP_LOW,
    ST_STOP_HIGH,
    ST_STOP_FREE
  } ipc_state_t;
endpackage

// ### hdl/ipc_bus_monitor.sv
// Purpose: synchronise the shared I2C lines and track bus ownership
// Assumes: lines are open drain and idle high
// Notes: start and stop are seen on the synchronised copies only
`timescale 1ns/1ps
module ipc_bus_monitor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sclSync,
  output logic sdaSync,
  output logic busBusy
);
  logic sclMeta_reg;
  logic sdaMeta_reg;
  logic sclSync_reg;
  logic sdaSync_reg;
  logic sclLast_reg;
  logic sdaLast_reg;
  logic busBusy_reg;
  logic startSeen;
  logic stopSeen;

  // Two-stage synchronisers plus a history stage for edge detection
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sclMeta_reg <= 1'b1;
      sdaMeta_reg <= 1'b1;
      sclSync_reg <= 1'b1;
      sdaSync_reg <= 1'b1;
      sclLast_reg <= 1'b1;
      sdaLast_reg <= 1'b1;
    end else begin
      sclMeta_reg <= sclIn;
      sdaMeta_reg <= sdaIn;
      sclSync_reg <= sclMeta_reg;
      sdaSync_reg <= sdaMeta_reg;
      sclLast_reg <= sclSync_reg;
      sdaLast_reg <= sdaSync_reg;
    end
  end

  // SDA moving while SCL stays high marks start or stop
  assign startSeen = sclSync_reg && sclLast_reg && sdaLast_reg && !sdaSync_reg;
  assign stopSeen = sclSync_reg && sclLast_reg && !sdaLast_reg && sdaSync_reg;

  // Busy from any start until the next stop, whoever issued it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busBusy_reg <= 1'b0;
    end else if (startSeen) begin
      busBusy_reg <= 1'b1;
    end else if (stopSeen) begin
      busBusy_reg <= 1'b0;
    end
  end

  assign sclSync = sclSync_reg;
  assign sdaSync = sdaSync_reg;
  assign busBusy = busBusy_reg;

  a_start_busy: assert property (@(posedge sys_clk) disable iff (rst) startSeen |=> busBusy_reg)
    else $error("bus not marked busy after start");

endmodule // ipc_bus_monitor

// ### hdl/ipc_proxy_ctrl.sv
// Purpose: per-port I2C proxy controllers regenerating remote accesses on the local bus
// Assumes: register port and I2C logic on sys_clk; link requests on linkClk
// Notes: one address byte and one data byte per access, then stop
// Operation
// - Accesses arriving from a remote serializer are replayed as controller frames locally.
// - The proxy permit bit resets to 0 and while clear remote accesses never reach the bus.
// - Software sets the permit bit when proxying is wanted, after which accesses are replayed.
// - The programmed counts let the SCL timing meet standard, fast or fast-plus modes.
// - The controller arbitrates and synchronises SCL with other parties on a shared bus.
// - Each receive port has its own independent proxy controller.
// - Contention between ports or other controllers is settled by waiting for an idle bus, then by bus arbitration.
// - Timing units follow the external reference, or an internal 25 MHz source until it runs.
// - SCL high lasts 40 ns times the high count plus 4.
// - SCL low lasts 40 ns times the low count plus 4.
// - The low count is also handed to the local target as its SDA setup delay.
// - Both counts reset to give at least 5 us per phase at 25 MHz.
`timescale 1ns/1ps
module ipc_proxy_ctrl #(
  parameter int NP = ipc_pkg::NUM_PORTS
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic linkClk,
  input wire logic linkRst,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  input wire logic [NP-1:0] linkReqValid,
  output logic [NP-1:0] linkReqReady,
  input wire logic [NP-1:0] linkReqRead,
  input wire logic [NP*7-1:0] linkReqAddr,
  input wire logic [NP*8-1:0] linkReqData,
  output logic [NP-1:0] linkRspValid,
  output logic [NP-1:0] linkRspAck,
  output logic [NP*8-1:0] linkRspData,
  input wire logic referenceClockInput,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic [NP*8-1:0] sdaSetupCount
);
  logic [7:0] genCtrl_reg;
  logic [7:0] portSel_reg;
  logic [7:0] regRdData_reg;
  logic permit;
  logic sclSync;
  logic sdaSync;
  logic busBusy;
  logic refMeta_reg;
  logic refSync_reg;
  logic refLast_reg;
  logic refEdge;
  logic [4:0] refQuiet_reg;
  logic refPresent_reg;
  logic [1:0] divCnt_reg;
  logic unitTick;
  logic [NP-1:0] sclPull;
  logic [NP-1:0] sdaPull;
  logic [NP-1:0] portActive;
  logic [NP*8-1:0] allHigh;
  logic [NP*8-1:0] allLow;
  logic sclOe_reg;
  logic sdaOe_reg;
  logic rdIdx;

  // Last unit index of a phase: count plus the fixed sync allowance, minus one
  function automatic logic [8:0] lastUnit(input logic [7:0] cnt);
    return {1'b0, cnt} + 9'(ipc_pkg::SCL_EXTRA_UNITS - 1);
  endfunction

  // Slots where this controller owns SDA and must watch for a lost bit
  function automatic logic ownsSlot(input logic [4:0] idx, input logic rd);
    return (idx < 5'(ipc_pkg::ADDR_ACK_BIT)) ||
      (!rd && idx > 5'(ipc_pkg::ADDR_ACK_BIT) && idx < 5'(ipc_pkg::FRAME_LAST_BIT));
  endfunction

  // Shared line monitor; every port sees the same wired bus
  ipc_bus_monitor uMon (
    .sys_clk(sys_clk),
    .rst(rst),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .sclSync(sclSync),
    .sdaSync(sdaSync),
    .busBusy(busBusy)
  );

  // Global control and port page registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      genCtrl_reg <= ipc_pkg::GEN_CTRL_RESET;
      portSel_reg <= ipc_pkg::PORT_SEL_RESET;
    end else if (regWrite) begin
      if (regAddr == ipc_pkg::OFS_GEN_CTRL) begin
        genCtrl_reg <= regWrData & ipc_pkg::GEN_CTRL_MASK;
      end
      if (regAddr == ipc_pkg::OFS_PORT_SEL) begin
        portSel_reg <= regWrData & ipc_pkg::PORT_SEL_MASK;
      end
    end
  end

  assign permit = genCtrl_reg[ipc_pkg::GEN_PERMIT_BIT];
  assign rdIdx = portSel_reg[ipc_pkg::SEL_RD_LSB];

  // Read data registered one cycle after the read strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      regRdData_reg <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        ipc_pkg::OFS_GEN_CTRL: regRdData_reg <= genCtrl_reg;
        ipc_pkg::OFS_PORT_SEL: regRdData_reg <= portSel_reg;
        ipc_pkg::OFS_SCL_HIGH: regRdData_reg <= allHigh[rdIdx*8 +: 8];
        ipc_pkg::OFS_SCL_LOW: regRdData_reg <= allLow[rdIdx*8 +: 8];
        ipc_pkg::OFS_PROXY_STS: begin
          regRdData_reg <= 8'h00;
          regRdData_reg[ipc_pkg::STS_ACTIVE_LSB +: NP] <= portActive;
          regRdData_reg[ipc_pkg::STS_BUS_BUSY_BIT] <= busBusy;
          regRdData_reg[ipc_pkg::STS_REF_BIT] <= refPresent_reg;
        end
        default: regRdData_reg <= 8'h00;
      endcase
    end
  end

  assign regRdData = regRdData_reg;

  // Reference pin is sampled, since it is far slower than sys_clk
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      refMeta_reg <= 1'b0;
      refSync_reg <= 1'b0;
      refLast_reg <= 1'b0;
    end else begin
      refMeta_reg <= referenceClockInput;
      refSync_reg <= refMeta_reg;
      refLast_reg <= refSync_reg;
    end
  end

  assign refEdge = refSync_reg && !refLast_reg;

  // Reference counts as present while edges keep arriving
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      refQuiet_reg <= 5'(ipc_pkg::REF_LOSS_CYCLES);
      refPresent_reg <= 1'b0;
    end else begin
      if (refEdge) begin
        refQuiet_reg <= 5'h00;
      end else if (refQuiet_reg != 5'(ipc_pkg::REF_LOSS_CYCLES)) begin
        refQuiet_reg <= refQuiet_reg + 5'h01;
      end
      refPresent_reg <= (refQuiet_reg != 5'(ipc_pkg::REF_LOSS_CYCLES));
    end
  end

  // Internal 25 MHz unit source, used until the reference runs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      divCnt_reg <= 2'h0;
    end else if (divCnt_reg == 2'(ipc_pkg::UNIT_CYCLES - 1)) begin
      divCnt_reg <= 2'h0;
    end else begin
      divCnt_reg <= divCnt_reg + 2'h1;
    end
  end

  assign unitTick = refPresent_reg ? refEdge : (divCnt_reg == 2'(ipc_pkg::UNIT_CYCLES - 1));

  a_int_tick: assert property (@(posedge sys_clk) disable iff (rst)
    (!refPresent_reg && divCnt_reg == 2'h3) |-> unitTick ##1 !unitTick)
    else $error("internal timing unit missing");

  // Wired-AND outputs: any port pulling drives the line low
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sclOe_reg <= 1'b0;
      sdaOe_reg <= 1'b0;
    end else begin
      sclOe_reg <= |sclPull;
      sdaOe_reg <= |sdaPull;
    end
  end

  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOe = sclOe_reg;
  assign sdaOe = sdaOe_reg;

  // One controller per receive port
  for (genvar g = 0; g < NP; g++) begin : gPort
    logic [7:0] highCount_reg;
    logic [7:0] lowCount_reg;
    logic lkBusy_reg;
    logic lkReqTog_reg;
    logic lkRead_reg;
    logic [6:0] lkAddr_reg;
    logic [7:0] lkData_reg;
    logic lkRspMeta_reg;
    logic lkRspSync_reg;
    logic lkRspLast_reg;
    logic lkRspValid_reg;
    logic lkRspAck_reg;
    logic [7:0] lkRspData_reg;
    logic reqMeta_reg;
    logic reqSync_reg;
    logic reqLast_reg;
    logic reqEdge;
    logic rspTog_reg;
    logic rspAck_reg;
    logic [7:0] rspData_reg;
    ipc_pkg::ipc_state_t state_reg;
    ipc_pkg::ipc_state_t prevState_reg;
    logic [8:0] unitCnt_reg;
    logic [4:0] bitIdx_reg;
    logic [17:0] txShift_reg;
    logic [17:0] rxShift_reg;
    logic rdReq_reg;
    logic hiSeen_reg;
    logic ackOk_reg;
    logic sclPull_reg;
    logic sdaPull_reg;
    logic [11:0] phaseCycles_reg;
    logic lostNow;
    logic highEnd;
    logic lowEnd;

    // Timing counts, one copy per port behind the page select
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        highCount_reg <= ipc_pkg::SCL_HIGH_RESET;
        lowCount_reg <= ipc_pkg::SCL_LOW_RESET;
      end else if (regWrite && portSel_reg[ipc_pkg::SEL_WR_LSB + g]) begin
        if (regAddr == ipc_pkg::OFS_SCL_HIGH) begin
          highCount_reg <= regWrData;
        end
        if (regAddr == ipc_pkg::OFS_SCL_LOW) begin
          lowCount_reg <= regWrData;
        end
      end
    end

    assign allHigh[g*8 +: 8] = highCount_reg;
    assign allLow[g*8 +: 8] = lowCount_reg;
    assign sdaSetupCount[g*8 +: 8] = lowCount_reg;

    // Link side: hold one request until its answer returns
    always_ff @(posedge linkClk) begin
      if (linkRst) begin
        lkBusy_reg <= 1'b0;
        lkReqTog_reg <= 1'b0;
        lkRead_reg <= 1'b0;
        lkAddr_reg <= 7'h00;
        lkData_reg <= 8'h00;
      end else if (linkReqValid[g] && !lkBusy_reg) begin
        lkBusy_reg <= 1'b1;
        lkReqTog_reg <= !lkReqTog_reg;
        lkRead_reg <= linkReqRead[g];
        lkAddr_reg <= linkReqAddr[g*7 +: 7];
        lkData_reg <= linkReqData[g*8 +: 8];
      end else if (lkRspSync_reg != lkRspLast_reg) begin
        lkBusy_reg <= 1'b0;
      end
    end

    // Answer toggle crosses back; its data stays frozen until the next answer
    always_ff @(posedge linkClk) begin
      if (linkRst) begin
        lkRspMeta_reg <= 1'b0;
        lkRspSync_reg <= 1'b0;
        lkRspLast_reg <= 1'b0;
        lkRspValid_reg <= 1'b0;
        lkRspAck_reg <= 1'b0;
        lkRspData_reg <= 8'h00;
      end else begin
        lkRspMeta_reg <= rspTog_reg;
        lkRspSync_reg <= lkRspMeta_reg;
        lkRspLast_reg <= lkRspSync_reg;
        lkRspValid_reg <= (lkRspSync_reg != lkRspLast_reg);
        if (lkRspSync_reg != lkRspLast_reg) begin
          lkRspAck_reg <= rspAck_reg;
          lkRspData_reg <= rspData_reg;
        end
      end
    end

    assign linkReqReady[g] = !lkBusy_reg;
    assign linkRspValid[g] = lkRspValid_reg;
    assign linkRspAck[g] = lkRspAck_reg;
    assign linkRspData[g*8 +: 8] = lkRspData_reg;

    // Request toggle synchroniser on the system side
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        reqMeta_reg <= 1'b0;
        reqSync_reg <= 1'b0;
        reqLast_reg <= 1'b0;
      end else begin
        reqMeta_reg <= lkReqTog_reg;
        reqSync_reg <= reqMeta_reg;
        reqLast_reg <= reqSync_reg;
      end
    end

    assign reqEdge = reqSync_reg != reqLast_reg;
    assign lostNow = state_reg == ipc_pkg::ST_HIGH && hiSeen_reg && sclSync && !sdaPull_reg &&
      !sdaSync && ownsSlot(bitIdx_reg, rdReq_reg);
    assign highEnd = hiSeen_reg && (!sclSync || (unitTick && unitCnt_reg == lastUnit(highCount_reg)));
    assign lowEnd = unitTick && unitCnt_reg == lastUnit(lowCount_reg);

    // Frame sequencer: start, 18 bit slots, stop, bus free time
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        state_reg <= ipc_pkg::ST_IDLE;
        unitCnt_reg <= 9'h000;
        bitIdx_reg <= 5'h00;
        txShift_reg <= 18'h3FFFF;
        rxShift_reg <= 18'h00000;
        rdReq_reg <= 1'b0;
        hiSeen_reg <= 1'b0;
        ackOk_reg <= 1'b0;
        sclPull_reg <= 1'b0;
        sdaPull_reg <= 1'b0;
        rspTog_reg <= 1'b0;
        rspAck_reg <= 1'b0;
        rspData_reg <= 8'h00;
      end else begin
        if (unitTick) begin
          unitCnt_reg <= unitCnt_reg + 9'h001;
        end
        unique case (state_reg)
          ipc_pkg::ST_IDLE: begin
            if (reqEdge && permit) begin
              rdReq_reg <= lkRead_reg;
              state_reg <= ipc_pkg::ST_WAIT_BUS;
            end else if (reqEdge) begin
              rspAck_reg <= 1'b0;
              rspData_reg <= 8'h00;
              rspTog_reg <= !rspTog_reg;
            end
          end
          ipc_pkg::ST_WAIT_BUS: begin
            // Only an idle bus after a stop may be claimed
            if (!busBusy && sclSync && sdaSync) begin
              sdaPull_reg <= 1'b1;
              txShift_reg <= {lkAddr_reg, lkRead_reg, 1'b1,
                lkRead_reg ? 8'hFF : lkData_reg, 1'b1}; // whole frame reloaded per claim
              unitCnt_reg <= 9'h000;
              state_reg <= ipc_pkg::ST_START;
            end
          end
          ipc_pkg::ST_START: begin
            if (unitTick && unitCnt_reg == lastUnit(highCount_reg)) begin
              sclPull_reg <= 1'b1;
              bitIdx_reg <= 5'h00;
              rxShift_reg <= 18'h00000;
              unitCnt_reg <= 9'h000;
              state_reg <= ipc_pkg::ST_LOW;
            end
          end
          ipc_pkg::ST_LOW: begin
            // Data changes one unit after SCL falls, never with it
            if (unitTick && unitCnt_reg == 9'h000) begin
              sdaPull_reg <= !txShift_reg[17];
            end
            if (lowEnd) begin
              sclPull_reg <= 1'b0;
              hiSeen_reg <= 1'b0;
              unitCnt_reg <= 9'h000;
              state_reg <= ipc_pkg::ST_HIGH;
            end
          end
          ipc_pkg::ST_HIGH: begin
            // Count only once SCL is really high, which honours stretching
            if (!hiSeen_reg) begin
              unitCnt_reg <= 9'h000;
              hiSeen_reg <= sclSync;
            end
            if (lostNow) begin
              sclPull_reg <= 1'b0;
              sdaPull_reg <= 1'b0;
              state_reg <= ipc_pkg::ST_WAIT_BUS;
            end else if (highEnd) begin
              rxShift_reg <= {rxShift_reg[16:0], sdaSync};
              txShift_reg <= {txShift_reg[16:0], 1'b1};
              sclPull_reg <= 1'b1;
              unitCnt_reg <= 9'h000;
              if (bitIdx_reg == 5'(ipc_pkg::ADDR_ACK_BIT) && sdaSync) begin
                ackOk_reg <= 1'b0;
                state_reg <= ipc_pkg::ST_STOP_LOW;
              end else if (bitIdx_reg == 5'(ipc_pkg::FRAME_LAST_BIT)) begin
                ackOk_reg <= rdReq_reg || !sdaSync;
                state_reg <= ipc_pkg::ST_STOP_LOW;
              end else begin
                bitIdx_reg <= bitIdx_reg + 5'h01;
                state_reg <= ipc_pkg::ST_LOW;
              end
            end
          end
          ipc_pkg::ST_STOP_LOW: begin
            if (unitTick && unitCnt_reg == 9'h000) begin
              sdaPull_reg <= 1'b1;
            end
            if (lowEnd) begin
              sclPull_reg <= 1'b0;
              hiSeen_reg <= 1'b0;
              unitCnt_reg <= 9'h000;
              state_reg <= ipc_pkg::ST_STOP_HIGH;
            end
          end
          ipc_pkg::ST_STOP_HIGH: begin
            if (!hiSeen_reg) begin
              unitCnt_reg <= 9'h000;
              hiSeen_reg <= sclSync;
            end else if (unitTick && unitCnt_reg == lastUnit(highCount_reg)) begin
              sdaPull_reg <= 1'b0;
              unitCnt_reg <= 9'h000;
              state_reg <= ipc_pkg::ST_STOP_FREE;
            end
          end
          ipc_pkg::ST_STOP_FREE: begin
            if (unitTick && unitCnt_reg == lastUnit(highCount_reg)) begin
              rspAck_reg <= ackOk_reg;
              rspData_reg <= (ackOk_reg && rdReq_reg) ? rxShift_reg[8:1] : 8'h00;
              rspTog_reg <= !rspTog_reg;
              state_reg <= ipc_pkg::ST_IDLE;
            end
          end
        endcase
      end
    end

    assign sclPull[g] = sclPull_reg;
    assign sdaPull[g] = sdaPull_reg;
    assign portActive[g] = state_reg != ipc_pkg::ST_IDLE;

    // Phase length helper for the timing checks
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        prevState_reg <= ipc_pkg::ST_IDLE;
        phaseCycles_reg <= 12'h000;
      end else begin
        prevState_reg <= state_reg;
        if (state_reg != prevState_reg || (state_reg == ipc_pkg::ST_HIGH && !hiSeen_reg)) begin
          phaseCycles_reg <= 12'h001;
        end else if (phaseCycles_reg != 12'hFFF) begin
          phaseCycles_reg <= phaseCycles_reg + 12'h001;
        end
      end
    end

    a_permit_blocks: assert property (@(posedge sys_clk) disable iff (rst)
      (state_reg == ipc_pkg::ST_IDLE && !permit) |=> state_reg == ipc_pkg::ST_IDLE && !sclPull_reg)
      else $error("access started while proxy not permitted");

    a_remote_regen: assert property (@(posedge sys_clk) disable iff (rst)
      (state_reg == ipc_pkg::ST_IDLE && reqEdge && permit) |=>
        state_reg == ipc_pkg::ST_WAIT_BUS ##1 (state_reg != ipc_pkg::ST_IDLE))
      else $error("permitted remote access not replayed");

    a_lost_release: assert property (@(posedge sys_clk) disable iff (rst)
      lostNow |=> !sclPull_reg && !sdaPull_reg && state_reg == ipc_pkg::ST_WAIT_BUS)
      else $error("lines not released after lost arbitration");

    a_wait_idle: assert property (@(posedge sys_clk) disable iff (rst)
      (state_reg == ipc_pkg::ST_WAIT_BUS && busBusy) |=> state_reg == ipc_pkg::ST_WAIT_BUS && !sdaPull_reg)
      else $error("bus claimed while another controller owns it");

    a_high_width: assert property (@(posedge sys_clk) disable iff (rst)
      (state_reg == ipc_pkg::ST_HIGH && highEnd && sclSync && !lostNow) |->
        int'(phaseCycles_reg) >= (int'(highCount_reg) + 3) * ipc_pkg::UNIT_CYCLES)
      else $error("SCL high phase too short");

    a_low_width: assert property (@(posedge sys_clk) disable iff (rst)
      (state_reg == ipc_pkg::ST_LOW && lowEnd) |->
        int'(phaseCycles_reg) >= (int'(lowCount_reg) + 3) * ipc_pkg::UNIT_CYCLES)
      else $error("SCL low phase too short");

    a_reset_counts: assert property (@(posedge sys_clk)
      rst |=> highCount_reg == 8'h7A && lowCount_reg == 8'h7A)
      else $error("timing counts wrong after reset");

    a_page_isolation: assert property (@(posedge sys_clk) disable iff (rst)
      (regWrite && regAddr == ipc_pkg::OFS_SCL_HIGH && !portSel_reg[g]) |=> $stable(highCount_reg))
      else $error("count of an unselected port changed");
  end

endmodule // ipc_proxy_ctrl

// ### sim/ipc_i2c_target.sv
// Purpose: behavioural target on the shared I2C bus
// Assumes: both lines idle high through pull-ups
// Notes: acks one address; reads return a fixed byte
`timescale 1ns/1ps
module ipc_i2c_target #(
  parameter logic [6:0] ADDR = 7'h2A,
  parameter logic [7:0] RDATA = 8'hC5
) (
  input wire logic scl,
  input wire logic sda,
  output logic pullLow
);
  logic [7:0] sh = 8'h00;
  logic hit = 1'b0;
  logic rd = 1'b0;
  int n = 0;
  initial pullLow = 1'b0;
  // Start condition restarts the bit count
  always @(negedge sda) if (scl) begin
    n = 0;
    hit = 1'b0;
  end
  // Sample on SCL rise, MSB first
  always @(posedge scl) begin
    sh = {sh[6:0], sda};
    n = n + 1;
    if (n == 8) begin
      hit = (sh[7:1] == ADDR);
      rd = sda;
    end
  end
  // SDA moves only while SCL is low, so no false start or stop
  always @(negedge scl) begin
    pullLow <= hit && (n == 8 || (rd && n > 8 && n < 17 && !RDATA[16-n]) || (!rd && n == 17));
  end
endmodule // ipc_i2c_target

// ### sim/test_ipc_proxy_ctrl.sv
// Purpose: self-checking bench for the proxy controller
// Assumes: reference pin idle at first, so the 40 ns unit is internal
// Notes: small counts keep each frame near a thousand cycles
`timescale 1ns/1ps
module test_ipc_proxy_ctrl;
  logic sys_clk = 1'b0, linkClk = 1'b0, rst = 1'b1, linkRst = 1'b1, regWrite = 1'b0;
  logic regRead = 1'b0, sclOut, sclOe, sdaOut, sdaOe, tgtPull, refPin = 1'b0;
  logic [7:0] regAddr = '0, regWrData = '0, regRdData;
  logic [1:0] linkReqValid = '0, linkReqRead = '0, linkReqReady, linkRspValid, linkRspAck;
  logic [13:0] linkReqAddr = '0;
  logic [15:0] linkReqData = '0, linkRspData, sdaSetupCount;
  int fails = 0, n_checks = 0, i;
  logic [7:0] rows [11][3] = '{'{8'h4C, 8'h03, 8'h03}, '{8'h0A, 8'h06, 8'h06},
    '{8'h0B, 8'h0C, 8'h0C}, '{8'h4C, 8'h11, 8'h11}, '{8'h0A, 8'h05, 8'h06},
    '{8'h4C, 8'hFF, 8'h33}, '{8'h0A, 8'h02, 8'h02}, '{8'h0B, 8'h03, 8'h03},
    '{8'h3F, 8'h5A, 8'h00}, '{8'h07, 8'hFF, 8'h00}, '{8'h05, 8'hFF, 8'h04}};
  // Wired-AND bus levels
  wire scl = sclOe ? sclOut : 1'b1;
  wire sda = (sdaOe ? sdaOut : 1'b1) && !tgtPull;
  ipc_proxy_ctrl #(.NP(2)) uut (.sys_clk(sys_clk), .rst(rst), .linkClk(linkClk),
    .linkRst(linkRst), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .linkReqValid(linkReqValid),
    .linkReqReady(linkReqReady), .linkReqRead(linkReqRead), .linkReqAddr(linkReqAddr),
    .linkReqData(linkReqData), .linkRspValid(linkRspValid), .linkRspAck(linkRspAck),
    .linkRspData(linkRspData), .referenceClockInput(refPin), .sclIn(scl), .sclOut(sclOut),
    .sclOe(sclOe), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .sdaSetupCount(sdaSetupCount));
  ipc_i2c_target tgt (.scl(scl), .sda(sda), .pullLow(tgtPull));
  // Clocks, link phase offset on purpose
  always #5 sys_clk = !sys_clk;
  initial begin
    #3.3;
    forever #7.5 linkClk = !linkClk;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    @(posedge sys_clk);
    chk(regRdData, e);
  endtask
  task automatic send(input int g, input logic r, input logic [6:0] a, input logic [7:0] d);
    @(posedge linkClk);
    linkReqValid[g] <= 1'b1;
    linkReqRead[g] <= r;
    linkReqAddr[g*7+:7] <= a;
    linkReqData[g*8+:8] <= d;
    do @(posedge linkClk); while (linkReqReady[g] !== 1'b1);
    linkReqValid[g] <= 1'b0;
  endtask
  task automatic rsp(input int g, input logic ea, input logic [7:0] ed);
    for (int t = 0; t < 30000 && linkRspValid[g] !== 1'b1; t++) @(posedge linkClk);
    if (linkRspValid[g] !== 1'b1) begin
      fails++;
      $display("MISMATCH t=%0t no answer on port %0d", $time, g);
    end
    chk({7'h00, linkRspAck[g]}, {7'h00, ea});
    chk(linkRspData[g*8+:8], ed);
  endtask
  // Cycles of one driven-low SCL phase
  task automatic lowPulse(input logic [7:0] e);
    int c = 0;
    while (sclOe !== 1'b1 && c < 9000) begin
      @(posedge sys_clk);
      c++;
    end
    c = 0;
    while (sclOe === 1'b1) begin
      @(posedge sys_clk);
      c++;
    end
    chk(c[7:0], e);
  endtask
  task automatic runRows;
    for (i = 0; i < 11; i++) begin
      wr(rows[i][0], rows[i][1]);
      rdc(rows[i][0], rows[i][2]);
    end
    $display("register rows done");
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    linkRst <= 1'b0;
    runRows();
    // Second reset in mid-run
    rst <= 1'b1;
    linkRst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    linkRst <= 1'b0;
    rdc(8'h0A, 8'h7A);
    rdc(8'h0B, 8'h7A);
    rdc(8'h05, 8'h00);
    repeat (4) @(posedge linkClk);
    send(0, 1'b0, 7'h2A, 8'h5A);
    rsp(0, 1'b0, 8'h00);
    $display("reset and refusal done");
    runRows();
    chk(sdaSetupCount[7:0], 8'h03);
    chk(sdaSetupCount[15:8], 8'h03);
    // Low phase is (3 + 4) units of 4 cycles
    send(0, 1'b0, 7'h2A, 8'h5A);
    lowPulse(8'h1C);
    rsp(0, 1'b1, 8'h00);
    send(0, 1'b1, 7'h2A, 8'h00);
    rsp(0, 1'b1, 8'hC5);
    send(0, 1'b0, 7'h11, 8'h00);
    rsp(0, 1'b0, 8'h00);
    // Both ports at once; the read loses and retries
    fork
      send(0, 1'b0, 7'h2A, 8'h33);
      send(1, 1'b1, 7'h2A, 8'h00);
    join
    fork
      rsp(0, 1'b1, 8'h00);
      rsp(1, 1'b1, 8'hC5);
    join
    $display("bus traffic done");
    // Reference pin runs at 40 ns, off the sys_clk edges; units now follow it
    fork
      forever #20 refPin = !refPin;
    join_none
    send(1, 1'b0, 7'h2A, 8'h3C);
    lowPulse(8'h1C);
    rdc(8'h07, 8'h32);
    rsp(1, 1'b1, 8'h00);
    $display("reference timing done");
    report_and_stop();
  end
  // Frames take tens of microseconds in all
  initial begin
    #500000;
    fails++;
    report_and_stop();
  end
endmodule // test_ipc_proxy_ctrl
